// >>> design/sensor_status_pkg.sv
/*
 * Holds the offsets, field positions, reset values and limits shared by the
 * status register bank and its helper modules.
 * Assumes 16-bit registers, byte offsets on an 8-bit register address.
 */
package sensor_status_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h1e;
    localparam logic [7:0] ADDR_FAULT = 8'h24;
    localparam logic [7:0] ADDR_CAUTION = 8'h26;
    localparam logic [7:0] ADDR_TEMP = 8'h28;
    localparam logic [7:0] ADDR_FIELD = 8'h2a;
    localparam logic [7:0] ADDR_ROT_COUNT = 8'h2c;
    localparam logic [7:0] ADDR_ROT_OFFSET = 8'h2e;
    localparam logic [7:0] ADDR_HYST_ANGLE = 8'h30;
    localparam logic [7:0] ADDR_FINE_ANGLE = 8'h32;
    localparam logic [7:0] ADDR_ZC_ANGLE = 8'h34;
    localparam logic [7:0] ADDR_DELTA_UPPER = 8'h36;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_CLR_FAULT_BIT = 8;
    localparam int CTRL_CLR_CAUTION_BIT = 9;
    localparam int FAULT_LOCK_LOSS_BIT = 7;
    localparam int FAULT_QUAD_BIT = 8;
    localparam int FAULT_AVG_BIT = 9;
    localparam int FAULT_SELFTEST_BIT = 10;
    localparam int FAULT_SUMMARY_BIT = 11;
    localparam int FAULT_SUPPLY_A_BIT = 2;
    localparam int FAULT_SUPPLY_D_BIT = 3;
    localparam int CAU_OVERFLOW_BIT = 0;
    localparam int CAU_FIELD_HIGH_BIT = 1;
    localparam int CAU_OVERRUN_BIT = 2;
    localparam int CAU_DELTA_WARN_BIT = 3;
    localparam int CAU_SATURATED_BIT = 4;
    localparam int CAU_NVM_CORR_BIT = 5;
    localparam int CAU_TEMP_RANGE_BIT = 6;
    localparam int CAU_EXT_FAIL_BIT = 7;
    localparam int CAU_SLEW_BIT = 8;
    localparam int CAU_CRC_BIT = 10;
    localparam int CAU_FORMAT_BIT = 11;
    localparam int PARITY_BIT = 12;
    localparam int SUPPLY_LOW_BIT = 13;
    localparam int SOURCE_SEL_BIT = 13;
    localparam int ANY_FAULT_BIT = 14;
    localparam int OFFSET_HELD_BIT = 14;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic SOURCE_SEL_RST = 1'b1;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] FAULT_USED = 16'h0780;
    localparam logic [15:0] CAUTION_USED = 16'h0dff;
    // Temperature is in eighths of a degree relative to 25 C
    localparam logic signed [13:0] TEMP_MIN = -14'sd680;
    localparam logic signed [13:0] TEMP_MAX = 14'sd1240;
    // 135 degrees at 4096 counts per rotation
    localparam logic signed [21:0] DELTA_WARN_LIMIT = 22'sd1536;
endpackage : sensor_status_pkg

// >>> design/flag_bank_if.sv
/*
 * Carries one sticky flag bank between the register bank and its latch.
 * Assumes the owner drives set, read and clear strobes in the clock domain.
 */
`timescale 1ns/1ps
interface flag_bank_if;
    logic [15:0] set;
    logic rd;
    logic clr;
    logic [15:0] value;
    modport owner (output set, output rd, output clr, input value);
    modport bank (input set, input rd, input clr, output value);
endinterface : flag_bank_if

// >>> design/sticky_flag_bank.sv
/*
 * Holds a bank of sticky flags cleared only where previously read.
 * Assumes set, read and clear strobes are synchronous one-cycle pulses.
 */
`timescale 1ns/1ps
module sticky_flag_bank
    import sensor_status_pkg::*;
(
    input wire logic i_clk,     // System clock
    input wire logic i_srst,    // Synchronous reset
    flag_bank_if.bank fb        // Strobes and flag value
);
    logic [15:0] flags_r;
    logic [15:0] snap_r;
    logic [15:0] flags_nxt;
    logic [15:0] snap_nxt;

    // ----------------------------------------------------------------
    // Next state: a new event wins over a clear in the same cycle
    // ----------------------------------------------------------------
    assign flags_nxt = (flags_r & ~(fb.clr ? snap_r : 16'h0000)) | fb.set; // [R23] [R24]
    assign snap_nxt = fb.rd ? flags_r : (fb.clr ? 16'h0000 : snap_r);      // [R24]
    assign fb.value = flags_r;

    // Flag and read snapshot registers
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            flags_r <= FLAGS_RST;
            snap_r <= FLAGS_RST;
        end
        else
        begin
            flags_r <= flags_nxt;
            snap_r <= snap_nxt;
        end
    end
endmodule : sticky_flag_bank

// >>> design/temp_limiter.sv
/*
 * Saturates the computed temperature and flags out-of-range readings.
 * Assumes the raw value is signed eighths of a degree relative to 25 C.
 */
`timescale 1ns/1ps
module temp_limiter
    import sensor_status_pkg::*;
(
    input wire logic signed [13:0] i_raw,   // Computed temperature
    output logic [11:0] o_reading,          // Saturated 12-bit reading
    output logic o_out_of_range             // Beyond the limits
);
    logic below;
    logic above;
    logic signed [13:0] limited;

    // ----------------------------------------------------------------
    // Compare and clamp
    // ----------------------------------------------------------------
    assign below = i_raw < TEMP_MIN;                                   // [R8]
    assign above = i_raw > TEMP_MAX;                                   // [R8]
    assign limited = below ? TEMP_MIN : (above ? TEMP_MAX : i_raw);    // [R8]
    assign o_reading = limited[11:0];                                  // [R12]
    assign o_out_of_range = below | above;
endmodule : temp_limiter

// >>> design/angle_sensor_status_turns_regs.sv
/*
 * Status register bank of the angle sensor: fault latch, caution, temperature,
 * field, rotation count and offset, angle readouts and upper rotation delta.
 * Assumes the serial interface decodes packets outside and presents one-cycle
 * read and write strobes with a byte offset; events arrive as sync pulses.
 */
`timescale 1ns/1ps

// Contract
// [R1] Fault bits 7..10 latch lock loss, quadrature, averaging and self-test faults.
// [R2] Fault bit 11 shows unmasked caution bits, forced zero by its mask bit.
// [R3] Caution bit 0 sets when rotations pass plus or minus 256.
// [R4] Caution bit 1 sets when field strength exceeds the high threshold.
// [R5] Caution bit 2 sets on an extended access started while busy.
// [R6] Caution bit 3 sets when rotation delta passes plus or minus 135 degrees.
// [R7] Caution bit 5 sets on a corrected memory read.
// [R8] Caution bit 6 sets outside -60..180 C; reading saturates there.
// [R9] Caution bit 7 sets when an extended write command fails.
// [R10] A packet failing its check is dropped and sets caution bit 10.
// [R11] Bad bit count, MOSI bit 15 or coding error sets caution bit 11.
// [R12] Temperature reads as signed eighths of a degree relative to 25 C.
// [R13] Rotation count is a 12-bit signed count in 45 or 180 degree units.
// [R14] Rotation count bit 13 picks PLL (1) or zero-cross (0) source.
// [R15] Bit 12 of parity words keeps an odd number of ones.
// [R16] Rotation offset shows 11 or 9 low delta bits per resolution.
// [R17] Offset bit 14 says captured at prior count read; clears once read.
// [R18] Angle readout bit 13 shows masked real-time supply-low flags.
// [R19] Readout bit 14 sets when any unmasked fault or caution bit is set.
// [R20] Angles are unsigned 12-bit; low-power mode always counts zero-cross. The fine angle reads as 15-bit unsigned here.
// [R21] Reading upper delta freezes the lower word; host reads upper first.
// [R22] Upper delta field is the top 9 delta bits sign-extended to 12.
// [R23] Fault bits stay set until read and then cleared.
// [R24] A clear removes only previously read bits; host reads first.
// [R25] Undefined bit positions read as zero.
module angle_sensor_status_turns_regs
(
    input wire logic i_clk,                     // 25 MHz system clock
    input wire logic i_srst,                    // Synchronous reset, high
    input wire logic i_rd,                      // Register read strobe
    input wire logic i_wr,                      // Register write strobe
    input wire logic [7:0] i_addr,              // Register byte offset
    input wire logic [15:0] i_wdata,            // Write data
    output logic [15:0] o_rdata,                // Read data
    output logic o_rvalid,                      // Read data valid pulse
    input wire logic i_lock_loss,               // PLL lost lock pulse
    input wire logic i_quad_fault,              // Quadrature integrity loss
    input wire logic i_avg_fault,               // Averaging corrupted
    input wire logic i_selftest_fail,           // Self-test failed
    input wire logic i_supply_low_a,            // Analog undervoltage, live
    input wire logic i_supply_low_d,            // Digital undervoltage, live
    input wire logic [15:0] i_fault_mask,       // Shadow fault mask bits
    input wire logic [15:0] i_caution_mask,     // Shadow caution mask bits
    input wire logic [11:0] i_field_gauss,      // Field strength
    input wire logic [11:0] i_field_high_threshold, // High field limit
    input wire logic i_ext_start,               // Extended access started
    input wire logic i_ext_busy,                // Extended access running
    input wire logic i_ext_cmd_fail,            // Extended command failed
    input wire logic i_nvm_corrected,           // Memory single-bit fix
    input wire logic i_saturated,               // Internal saturation
    input wire logic i_slew_warn,               // Slew limiting applied
    input wire logic i_crc_fail,                // Packet check failed
    input wire logic i_bitcount_err,            // Bad packet length
    input wire logic i_mosi_bit15,              // MOSI bit 15 was one
    input wire logic i_manchester_err,          // Line coding error
    input wire logic signed [13:0] i_temp_raw,  // Computed temperature
    input wire logic [11:0] i_turns_pll,        // Count from PLL angle
    input wire logic [11:0] i_turns_zcd,        // Count from zero-cross angle
    input wire logic i_low_power,               // Low-power mode active
    input wire logic i_res45,                   // 45-degree turns resolution
    input wire logic signed [21:0] i_rot_delta, // Rotation delta counter
    input wire logic [11:0] i_hyst_angle,       // Hysteresis angle
    input wire logic [14:0] i_fine_angle,       // 15-bit angle
    input wire logic [11:0] i_zc_angle,         // Zero-cross angle
    input wire logic i_lower_rd,                // Lower delta word read
    output logic [11:0] o_delta_lower,          // Frozen lower delta
    output logic o_delta_lower_held,            // Lower delta is frozen
    output logic [11:0] o_turns_count,          // Selected rotation count
    output logic o_any_fault                    // Unmasked fault summary
);
    import sensor_status_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Parity bit making a 16-bit word hold an odd number of ones
    function automatic logic [15:0] with_parity(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[PARITY_BIT] = ~^{w[15:13], w[11:0]};
        return r;
    endfunction : with_parity

    flag_bank_if fault_if ();
    flag_bank_if caution_if ();

    logic [15:0] rdata_r;
    logic rvalid_r;
    logic [7:0] raddr_r;
    logic source_sel_r;
    logic [10:0] offset_cap_r;
    logic offset_held_r;
    logic [11:0] lower_r;
    logic lower_held_r;
    logic [11:0] turns_r;
    logic any_fault_r;

    logic [11:0] temp_reading;
    logic temp_oor;
    logic rd_fault, rd_caution, rd_count, rd_offset, rd_upper;
    logic wr_ctrl, wr_count;
    logic [15:0] fault_live, caution_live;
    logic cau_summary, any_fault, supply_low;
    logic over_flow, delta_warn, field_high, overrun, link_fmt;
    logic [11:0] turns_sel;
    logic [10:0] offset_live;
    logic [15:0] w_fault, w_caution, w_temp, w_field, w_count, w_offset;
    logic [15:0] w_hyst, w_fine, w_zc, w_upper;
    logic [15:0] rdata_nxt;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    sticky_flag_bank u_fault (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .fb     (fault_if)
    );

    sticky_flag_bank u_caution (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .fb     (caution_if)
    );

    temp_limiter u_temp (
        .i_raw          (i_temp_raw),
        .o_reading      (temp_reading),
        .o_out_of_range (temp_oor)
    );

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    assign rd_fault = i_rd && (i_addr == ADDR_FAULT);
    assign rd_caution = i_rd && (i_addr == ADDR_CAUTION);
    assign rd_count = i_rd && (i_addr == ADDR_ROT_COUNT);
    assign rd_offset = i_rd && (i_addr == ADDR_ROT_OFFSET);
    assign rd_upper = i_rd && (i_addr == ADDR_DELTA_UPPER);
    assign wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    assign wr_count = i_wr && (i_addr == ADDR_ROT_COUNT);

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    assign over_flow = i_rot_delta[21] != i_rot_delta[20];                        // [R3]
    assign delta_warn = (i_rot_delta > DELTA_WARN_LIMIT) || (i_rot_delta < -DELTA_WARN_LIMIT); // [R6]
    assign field_high = i_field_gauss > i_field_high_threshold;                   // [R4]
    assign overrun = i_ext_start && i_ext_busy;                                   // [R5]
    assign link_fmt = i_bitcount_err | i_mosi_bit15 | i_manchester_err;           // [R11]

    // Fault latch set and clear strobes
    assign fault_if.set = {5'h00, i_selftest_fail, i_avg_fault, i_quad_fault,     // [R1]
                           i_lock_loss, 7'h00};
    assign fault_if.rd = rd_fault;
    assign fault_if.clr = wr_ctrl && i_wdata[CTRL_CLR_FAULT_BIT];                 // [R23]

    // Caution set and clear strobes
    assign caution_if.set = {4'h0, link_fmt, i_crc_fail, 1'b0, i_slew_warn,       // [R10] [R11]
                             i_ext_cmd_fail, temp_oor, i_nvm_corrected,           // [R7] [R8] [R9]
                             i_saturated, delta_warn, overrun, field_high, over_flow};
    assign caution_if.rd = rd_caution;
    assign caution_if.clr = wr_ctrl && i_wdata[CTRL_CLR_CAUTION_BIT];             // [R24]

    // ----------------------------------------------------------------
    // Summaries
    // ----------------------------------------------------------------
    assign caution_live = caution_if.value & CAUTION_USED;                        // [R25]
    assign cau_summary = (|(caution_live & ~i_caution_mask)) && !i_fault_mask[FAULT_SUMMARY_BIT]; // [R2]
    assign fault_live = (fault_if.value & FAULT_USED) | ({15'h0000, cau_summary} << FAULT_SUMMARY_BIT);
    assign any_fault = (|(fault_live & ~i_fault_mask)) || (|(caution_live & ~i_caution_mask)); // [R19]
    assign supply_low = (i_supply_low_a && !i_fault_mask[FAULT_SUPPLY_A_BIT])      // [R18]
                     || (i_supply_low_d && !i_fault_mask[FAULT_SUPPLY_D_BIT]);

    // Rotation source and offset selection
    assign turns_sel = (i_low_power || !source_sel_r) ? i_turns_zcd : i_turns_pll; // [R14] [R20]
    assign offset_live = i_res45 ? {2'b00, i_rot_delta[8:0]} : i_rot_delta[10:0]; // [R16]

    // ----------------------------------------------------------------
    // Word composition
    // ----------------------------------------------------------------
    assign w_fault = fault_live;
    assign w_caution = caution_live;
    assign w_temp = {4'h0, temp_reading};                                         // [R12]
    assign w_field = {4'h0, i_field_gauss};
    assign w_count = with_parity({2'b00, source_sel_r, 1'b0, turns_r});            // [R13] [R15]
    assign w_offset = with_parity({1'b0, offset_held_r, 3'b000,                    // [R17]
                                   offset_held_r ? offset_cap_r : offset_live});
    assign w_hyst = with_parity({1'b0, any_fault, supply_low, 1'b0, i_hyst_angle}); // [R18] [R20]
    assign w_fine = {1'b0, i_fine_angle};                                          // [R25]
    assign w_zc = with_parity({1'b0, any_fault, supply_low, 1'b0, i_zc_angle});   // [R19] [R20]
    assign w_upper = with_parity({1'b0, any_fault, source_sel_r, 1'b0,            // [R22]
                                  {3{i_rot_delta[20]}}, i_rot_delta[20:12]});

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        case (i_addr)
            ADDR_FAULT: rdata_nxt = w_fault;
            ADDR_CAUTION: rdata_nxt = w_caution;
            ADDR_TEMP: rdata_nxt = w_temp;
            ADDR_FIELD: rdata_nxt = w_field;
            ADDR_ROT_COUNT: rdata_nxt = w_count;
            ADDR_ROT_OFFSET: rdata_nxt = w_offset;
            ADDR_HYST_ANGLE: rdata_nxt = w_hyst;
            ADDR_FINE_ANGLE: rdata_nxt = w_fine;
            ADDR_ZC_ANGLE: rdata_nxt = w_zc;
            ADDR_DELTA_UPPER: rdata_nxt = w_upper;
            default: rdata_nxt = 16'h0000;                                         // [R25]
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Read data port
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            raddr_r <= 8'h00;
        end
        else
        begin
            rvalid_r <= i_rd;
            if (i_rd)
            begin
                rdata_r <= rdata_nxt;
                raddr_r <= i_addr;
            end
        end
    end

    // Rotation source select and count sample
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            source_sel_r <= SOURCE_SEL_RST;
            turns_r <= 12'h000;
        end
        else
        begin
            if (wr_count)
                source_sel_r <= i_wdata[SOURCE_SEL_BIT];                           // [R14]
            turns_r <= turns_sel;                                                  // [R13]
        end
    end

    // Offset captured on a rotation count read, released by its own read
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            offset_cap_r <= 11'h000;
            offset_held_r <= 1'b0;
        end
        else if (rd_count)
        begin
            offset_cap_r <= offset_live;                                           // [R17]
            offset_held_r <= 1'b1;
        end
        else if (rd_offset)
            offset_held_r <= 1'b0;                                                 // [R17]
    end

    // Lower delta frozen on an upper read, released by the lower read
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            lower_r <= 12'h000;
            lower_held_r <= 1'b0;
        end
        else if (rd_upper)
        begin
            lower_r <= i_rot_delta[11:0];                                          // [R21]
            lower_held_r <= 1'b1;
        end
        else if (i_lower_rd)
            lower_held_r <= 1'b0;
    end

    // Fault summary output
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            any_fault_r <= 1'b0;
        else
            any_fault_r <= any_fault;
    end

    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;
    assign o_delta_lower = lower_r;
    assign o_delta_lower_held = lower_held_r;
    assign o_turns_count = turns_r;
    assign o_any_fault = any_fault_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence count_read_s;
        rd_count;
    endsequence
    sequence offset_read_s;
        rd_offset;
    endsequence

    lock_loss_latch_a: assert property (i_lock_loss |=> fault_if.value[FAULT_LOCK_LOSS_BIT]) // [R1]
        else $error("lock loss not latched");
    summary_mask_a: assert property ((rd_fault && i_fault_mask[FAULT_SUMMARY_BIT])           // [R2]
        |=> !o_rdata[FAULT_SUMMARY_BIT])
        else $error("masked summary bit read as one");
    overrun_flag_a: assert property (overrun |=> caution_if.value[CAU_OVERRUN_BIT])          // [R5]
        else $error("overrun not flagged");
    format_flag_a: assert property (i_mosi_bit15 |=> caution_if.value[CAU_FORMAT_BIT])       // [R11]
        else $error("format fault not flagged");
    parity_odd_a: assert property ((o_rvalid && (raddr_r == ADDR_ROT_COUNT                   // [R15]
        || raddr_r == ADDR_DELTA_UPPER || raddr_r == ADDR_ZC_ANGLE)) |-> ^o_rdata)
        else $error("parity word not odd");
    offset_held_a: assert property ((count_read_s ##1 !rd_offset ##1 offset_read_s) |=> (o_rdata[OFFSET_HELD_BIT] // [R17]
        && !offset_held_r))
        else $error("offset held flag wrong");
    delta_freeze_a: assert property (rd_upper |=> (o_delta_lower_held                        // [R21]
        && o_delta_lower == $past(i_rot_delta[11:0])))
        else $error("lower delta not frozen");
    fault_sticky_a: assert property ((fault_if.value[FAULT_SELFTEST_BIT] && !fault_if.clr)   // [R23]
        |=> fault_if.value[FAULT_SELFTEST_BIT])
        else $error("fault bit dropped without clear");
    temp_range_a: assert property (o_rvalid && raddr_r == ADDR_TEMP                          // [R8]
        |-> ($signed(o_rdata[11:0]) >= $signed(TEMP_MIN[11:0])))
        else $error("temperature below limit");
endmodule : angle_sensor_status_turns_regs

// >>> tb/host_model.sv
/*
 * Host model: register reads and writes.
 * Assumes strobes are taken on rising edges.
 */
`timescale 1ns/1ps
module host_model
(
    input wire logic i_clk,           // Clock
    output logic o_rd = '0,           // Read strobe
    output logic o_wr = '0,           // Write strobe
    output logic [7:0] o_addr = '0,   // Offset
    output logic [15:0] o_wdata = '0  // Write data
);
    // One strobe cycle between falling edges
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_rd <= !w;
        o_wr <= w;
        o_addr <= a;
        o_wdata <= {1'b0, d[14:0]};
        @(negedge i_clk);
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : access
endmodule : host_model

// >>> tb/angle_sensor_status_turns_regs_bench.sv
/*
 * Bench for the status bank; expected reads queued.
 * Assumes a 40 ns clock and synchronous reset.
 */
`timescale 1ns/1ps
module angle_sensor_status_turns_regs_bench;
    import sensor_status_pkg::*;
    logic i_clk = '0, i_srst = '1, i_rd, i_wr, o_rvalid, o_delta_lower_held, o_any_fault, i_lower_rd = '0;
    logic i_lock_loss = '0, i_quad_fault = '0, i_avg_fault = '0, i_selftest_fail = '0, i_crc_fail = '0;
    logic i_supply_low_a = '0, i_supply_low_d = '0, i_ext_start = '0, i_ext_busy = '0, i_ext_cmd_fail = '0;
    logic i_nvm_corrected = '0, i_saturated = '0, i_slew_warn = '0, i_bitcount_err = '0, i_mosi_bit15 = '0;
    logic i_manchester_err = '0, i_low_power = '0, i_res45 = '0;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, o_rdata, i_fault_mask = '1, i_caution_mask = '1, w, seed = 16'hc4af, expq[$];
    logic [11:0] i_field_gauss = '0, i_field_high_threshold = '1, i_turns_pll = '0, i_turns_zcd = '0;
    logic [11:0] i_hyst_angle = '0, i_zc_angle = '0, o_delta_lower, o_turns_count;
    logic [14:0] i_fine_angle = '0;
    logic signed [13:0] i_temp_raw = '0;
    logic signed [21:0] i_rot_delta = '0;
    int err_total = 0, n_tests = 0, cyc = 0;
    host_model host (.i_clk, .o_rd(i_rd), .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
    angle_sensor_status_turns_regs dut (.i_clk, .i_srst, .i_rd, .i_wr, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
        .i_lock_loss, .i_quad_fault, .i_avg_fault, .i_selftest_fail, .i_supply_low_a, .i_supply_low_d,
        .i_fault_mask, .i_caution_mask, .i_field_gauss, .i_field_high_threshold, .i_ext_start, .i_ext_busy,
        .i_ext_cmd_fail, .i_nvm_corrected, .i_saturated, .i_slew_warn, .i_crc_fail, .i_bitcount_err,
        .i_mosi_bit15, .i_manchester_err, .i_temp_raw, .i_turns_pll, .i_turns_zcd, .i_low_power, .i_res45,
        .i_rot_delta, .i_hyst_angle, .i_fine_angle, .i_zc_angle, .i_lower_rd, .o_delta_lower,
        .o_delta_lower_held, .o_turns_count, .o_any_fault);
    // Clock and 3000-cycle ceiling
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            test_done();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: read %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
        expq.push_back(e);
        host.access(1'b0, a, 16'h0000);
    endtask : rd_exp
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Answers compared in arrival order
    always @(negedge i_clk)
        if (o_rvalid === 1'b1)
            check(o_rdata, expq.pop_front());
    // Main sequence
    initial
    begin
        repeat (16) @(negedge i_clk);
        i_srst = 1'b0;
        {i_lock_loss, i_quad_fault, i_avg_fault, i_selftest_fail} = 4'hf;
        @(negedge i_clk);
        {i_lock_loss, i_quad_fault, i_avg_fault, i_selftest_fail} = 4'h0;
        rd_exp(ADDR_FAULT, FAULT_USED);
        host.access(1'b1, ADDR_CTRL, 16'h0100);
        rd_exp(ADDR_FAULT, 16'h0000);
        i_caution_mask = 16'h0000;
        i_fault_mask = 16'hf7ff;
        i_crc_fail = 1'b1;
        @(negedge i_clk);
        i_crc_fail = 1'b0;
        rd_exp(ADDR_CAUTION, 16'h0400);
        rd_exp(ADDR_FAULT, 16'h0800);
        seed = lfsr(seed);
        i_hyst_angle = seed[11:0];
        w = {4'h4, seed[11:0]};
        rd_exp(ADDR_HYST_ANGLE, w | {3'h0, ~^w, 12'h000});
        host.access(1'b1, ADDR_CTRL, 16'h0200);
        rd_exp(ADDR_CAUTION, 16'h0000);
        repeat (4)
        begin
            seed = lfsr(seed);
            i_temp_raw = {{4{seed[9]}}, seed[9:0]};
            rd_exp(ADDR_TEMP, {4'h0, {2{seed[9]}}, seed[9:0]});
        end
        i_temp_raw = 14'sh07d0;
        rd_exp(ADDR_TEMP, 16'h04d8);
        rd_exp(ADDR_CAUTION, 16'h0040);
        i_fine_angle = seed[14:0];
        rd_exp(ADDR_FINE_ANGLE, {1'b0, seed[14:0]});
        rd_exp(8'h40, 16'h0000);
        i_rot_delta = 22'sh0017a5;
        i_turns_pll = seed[11:0];
        w = {4'h2, seed[11:0]};
        rd_exp(ADDR_ROT_COUNT, w | {3'h0, ~^w, 12'h000});
        check({4'h0, o_turns_count}, {4'h0, seed[11:0]});
        rd_exp(ADDR_ROT_OFFSET, 16'h57a5);
        rd_exp(ADDR_ROT_OFFSET, 16'h07a5);
        rd_exp(ADDR_CAUTION, 16'h0048);
        rd_exp(ADDR_DELTA_UPPER, 16'h6001);
        check({3'h0, o_delta_lower_held, o_delta_lower}, 16'h17a5);
        i_lower_rd = 1'b1;
        i_turns_zcd = ~seed[11:0];
        host.access(1'b1, ADDR_ROT_COUNT, 16'h0000);
        i_lower_rd = 1'b0;
        @(negedge i_clk);
        check({3'h0, o_delta_lower_held, o_delta_lower}, 16'h07a5);
        check({4'h0, o_turns_count}, {4'h0, ~seed[11:0]});
        check({15'h0000, o_any_fault}, 16'h0001);
        {i_mosi_bit15, i_ext_start, i_ext_busy} = 3'h7;
        repeat (2) @(negedge i_clk);
        test_done();
    end
endmodule : angle_sensor_status_turns_regs_bench
